// >>> rtl/i2cs_addr_ack_slave.sv
// Purpose: two-wire slave receive engine: conditions, address, acknowledge
// Assumes: clk_sys_in far faster than the bus clock; pins are open-drain
// Notes: transmit data path is outside this block
// Functional notes
// - Stop is data rising while clock is high.
// - Stop counts only after one clock-low interval since Start.
// - Restart acts like Start and restarts the engine at the address byte.
// - 10-bit full write match sets prior-match flag until cleared.
// - Start/Stop irq enables add flags only where mode lacks them.
// - Ninth clock pulse is the acknowledge slot, active low.
// - Sampled acknowledge level goes to received-ack status.
// - Hold enables clear: auto ack; else software ack value.
// - No ack when buffer full or overflow already set.
// - Ack-time status set after eighth fall when hold enabled.
// - Start/Stop mode raises interrupt flag on each condition.
// - Match first byte with primary address and mask.
// - Match first byte also with secondary address and mask.
// - 7-bit mode ignores address byte LSB.
// - 10-bit high byte is 11110, A9, A8, zero.
// - 10-bit: update-address flag and clock hold after each write address byte.
// - 10-bit read only after full write match via Restart.
// - Matching write address clears read/write status, loads, acks.
// - Overflow withholds address ack; overwrite enable relaxes it.
// - Interrupt flag set per byte, held until software clears.
// - Stretch enable holds clock after each acked write byte until release.
// - Start sets start-seen, read clears full, Stop sets stop-seen; here a read clears full only when it empties the FIFO.
// - Data changes while clock low, sampled on clock rise.
// - Start is data falling while clock is high.
// - Bus pins are open-drain: pulled low or released.
`timescale 1ns/1ps
`include "i2cs_defines.svh"
module i2cs_addr_ack_slave
  import i2cs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic enable_in,
  input wire logic [1:0] port_mode_select_in,
  input wire logic [7:0] own_address_primary_in,
  input wire logic [7:0] own_address_secondary_in,
  input wire logic [7:0] address_mask_primary_in,
  input wire logic [7:0] address_mask_secondary_in,
  input wire logic address_hold_enable_in,
  input wire logic data_hold_enable_in,
  input wire logic start_irq_enable_in,
  input wire logic stop_irq_enable_in,
  input wire logic stretch_enable_in,
  input wire logic buffer_overwrite_enable_in,
  input wire logic ack_data_value_in,
  input wire logic clock_release_in,
  input wire logic own_address_write_in,
  input wire logic irq_clear_in,
  input wire logic overflow_clear_in,
  input wire logic rx_read_in,
  output logic [7:0] rx_data_out,
  output logic buffer_full_flag_out,
  output logic port_interrupt_flag_out,
  output logic receive_overflow_flag_out,
  output logic update_address_flag_out,
  output logic ack_time_status_out,
  output logic received_ack_status_out,
  output logic read_write_status_out,
  output logic start_seen_out,
  output logic stop_seen_out
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_now;
  logic sda_now;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic stop_valid;
  logic low_seen_reg;
  i2cs_state_t state_reg;
  i2cs_phase_t phase_reg;
  logic [`I2CS_BIT_CNT_W-1:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic accept_reg;
  logic go_on_reg;
  logic wait_addr_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic line_low_reg;
  logic irq_reg;
  logic ovf_reg;
  logic upd_addr_reg;
  logic ack_time_reg;
  logic rx_ack_reg;
  logic rw_reg;
  logic start_seen_reg;
  logic stop_seen_reg;
  logic prior_match_reg;
  logic ten_bit;
  logic ss_mode;
  logic active;
  logic byte_done;
  logic ack_done;
  logic hi_ok;
  logic hi_match;
  logic lo_match;
  logic match7;
  logic matched;
  logic overflow_cond;
  logic accept;
  logic sw_ack;
  logic ack_pol;
  logic hold8;

  i2cs_fifo_if #(.W(`I2CS_DATA_W)) rxq ();

  i2cs_rx_fifo #(.W(`I2CS_DATA_W), .D(`I2CS_FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .f(rxq)
  );

  // Masked compare of bits 7:1; mask bit set means compare
  function automatic logic addr_hit(input logic [7:0] b,
    input logic [7:0] a, input logic [7:0] m);
    return ((b ^ a) & m & `I2CS_ADDR_CMP_MASK) == 8'h00;
  endfunction

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_sync_reg <= {2{`I2CS_LINE_IDLE}};
      sda_sync_reg <= {2{`I2CS_LINE_IDLE}};
      scl_prev_reg <= `I2CS_LINE_IDLE;
      sda_prev_reg <= `I2CS_LINE_IDLE;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  assign scl_now = scl_sync_reg[1];
  assign sda_now = sda_sync_reg[1];
  assign scl_rise = scl_now && !scl_prev_reg;
  assign scl_fall = !scl_now && scl_prev_reg;
  assign start_det = enable_in && scl_now && scl_prev_reg &&
    !sda_now && sda_prev_reg;
  assign stop_det = enable_in && scl_now && scl_prev_reg &&
    sda_now && !sda_prev_reg;
  assign stop_valid = stop_det && low_seen_reg;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_seen_reg <= 1'b0;
    end else if (start_det || stop_valid) begin
      low_seen_reg <= 1'b0;
    end else if (start_seen_reg && !scl_now) begin
      low_seen_reg <= 1'b1;
    end
  end

  assign ten_bit = port_mode_select_in[`I2CS_MODE_TEN_POS];
  assign ss_mode = port_mode_select_in[`I2CS_MODE_SSIRQ_POS];
  assign active = enable_in && !start_det && !stop_valid;
  assign byte_done = active && state_reg == ST_BITS && scl_fall &&
    bit_cnt_reg == `I2CS_BITS_PER_BYTE;
  assign ack_done = active && state_reg == ST_ACK && scl_fall;

  assign hi_ok = shift_reg[7:3] == `I2CS_TEN_HI_PATTERN &&
    shift_reg[`I2CS_A98_HI:`I2CS_A98_LO] ==
    own_address_primary_in[`I2CS_A98_HI:`I2CS_A98_LO];
  assign hi_match = hi_ok &&
    (!shift_reg[`I2CS_RW_POS] || prior_match_reg);
  assign lo_match = shift_reg == own_address_primary_in;
  assign match7 =
    addr_hit(shift_reg, own_address_primary_in, address_mask_primary_in) ||
    addr_hit(shift_reg, own_address_secondary_in,
      address_mask_secondary_in);

  always_comb begin
    unique case (phase_reg)
      PH_ADDR: matched = ten_bit ? hi_match : match7;
      PH_LO: matched = lo_match;
      PH_DATA: matched = 1'b1;
      default: matched = 1'b0;
    endcase
  end

  // overflow blocks the ack; full FIFO refuses too
  assign overflow_cond = (rxq.out_valid && !buffer_overwrite_enable_in) ||
    ovf_reg || !rxq.in_ready;
  assign accept = matched && !overflow_cond;
  // software ack when a hold option is on
  assign sw_ack = address_hold_enable_in || data_hold_enable_in;
  assign ack_pol = !sw_ack || !ack_data_value_in;
  assign hold8 = matched &&
    (phase_reg == PH_DATA ? data_hold_enable_in : address_hold_enable_in);

  assign rxq.in_valid = byte_done && accept;
  assign rxq.in_data = shift_reg;
  assign rxq.out_ready = rx_read_in;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_ADDR;
      bit_cnt_reg <= '0;
      shift_reg <= 8'h00;
      accept_reg <= 1'b0;
      go_on_reg <= 1'b0;
      wait_addr_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (!enable_in || stop_valid) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_ADDR;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_BITS;
      phase_reg <= PH_ADDR;
      bit_cnt_reg <= '0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          bit_cnt_reg <= '0;
        end
        ST_BITS: begin
          if (scl_rise && bit_cnt_reg != `I2CS_BITS_PER_BYTE) begin
            shift_reg <= {shift_reg[6:0], sda_now};
            bit_cnt_reg <= bit_cnt_reg + `I2CS_BIT_CNT_W'(1);
          end else if (byte_done) begin
            bit_cnt_reg <= '0;
            accept_reg <= accept;
            if (!matched && phase_reg != PH_LO) begin
              state_reg <= ST_IDLE;
            end else if (hold8) begin
              state_reg <= ST_HOLD8;
              scl_oe_reg <= 1'b1;
            end else begin
              state_reg <= ST_ACK;
              sda_oe_reg <= accept && ack_pol;
            end
          end
        end
        ST_HOLD8: begin
          if (clock_release_in) begin
            state_reg <= ST_ACK;
            sda_oe_reg <= accept_reg && ack_pol;
          end
        end
        ST_ACK: begin
          // clock freed a cycle after the ack, so data leads clock
          if (scl_oe_reg) begin
            scl_oe_reg <= 1'b0;
          end
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            if (phase_reg == PH_ADDR && ten_bit && sda_oe_reg &&
                !rw_reg) begin
              phase_reg <= PH_LO;
              wait_addr_reg <= 1'b1;
              go_on_reg <= 1'b1;
              state_reg <= ST_HOLD9;
              scl_oe_reg <= 1'b1;
            end else if (phase_reg == PH_LO) begin
              phase_reg <= PH_DATA;
              wait_addr_reg <= 1'b1;
              go_on_reg <= sda_oe_reg;
              state_reg <= ST_HOLD9;
              scl_oe_reg <= 1'b1;
            end else if (!sda_oe_reg || rw_reg) begin
              // Read data path lives elsewhere, so release here
              state_reg <= ST_IDLE;
            end else if (stretch_enable_in) begin
              phase_reg <= PH_DATA;
              wait_addr_reg <= 1'b0;
              go_on_reg <= 1'b1;
              state_reg <= ST_HOLD9;
              scl_oe_reg <= 1'b1;
            end else begin
              phase_reg <= PH_DATA;
              state_reg <= ST_BITS;
            end
          end
        end
        ST_HOLD9: begin
          if (wait_addr_reg ? own_address_write_in : clock_release_in) begin
            scl_oe_reg <= 1'b0;
            state_reg <= go_on_reg ? ST_BITS : ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_low_reg <= 1'b0;
    end else begin
      line_low_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_reg <= 1'b0;
    end else if ((start_det && (ss_mode || start_irq_enable_in)) ||
        (stop_valid && (ss_mode || stop_irq_enable_in)) ||
        (byte_done && hold8) ||
        (ack_done && (sda_oe_reg || phase_reg == PH_LO))) begin
      irq_reg <= 1'b1;
    end else if (irq_clear_in) begin
      irq_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ovf_reg <= 1'b0;
    end else if (byte_done && matched &&
        ((rxq.out_valid && !buffer_overwrite_enable_in) ||
        !rxq.in_ready)) begin
      ovf_reg <= 1'b1;
    end else if (overflow_clear_in) begin
      ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      upd_addr_reg <= 1'b0;
    end else if (ack_done && ten_bit && (phase_reg == PH_LO ||
        (phase_reg == PH_ADDR && sda_oe_reg && !rw_reg))) begin
      upd_addr_reg <= 1'b1;
    end else if (own_address_write_in) begin
      upd_addr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_time_reg <= 1'b0;
    end else if (byte_done && matched && sw_ack) begin
      ack_time_reg <= 1'b1;
    end else if (ack_done || start_det || stop_valid || !enable_in) begin
      ack_time_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_ack_reg <= 1'b0;
    end else if (active && state_reg == ST_ACK && scl_rise) begin
      rx_ack_reg <= sda_now;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rw_reg <= 1'b0;
    end else if (byte_done && matched && phase_reg == PH_ADDR) begin
      rw_reg <= shift_reg[`I2CS_RW_POS];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else if (start_det) begin
      start_seen_reg <= 1'b1;
      stop_seen_reg <= 1'b0;
    end else if (stop_valid) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prior_match_reg <= 1'b0;
    end else if (stop_valid) begin
      prior_match_reg <= 1'b0;
    end else if (byte_done && ten_bit && phase_reg == PH_ADDR &&
        (!hi_ok || !shift_reg[`I2CS_RW_POS])) begin
      prior_match_reg <= 1'b0;
    end else if (ack_done && phase_reg == PH_LO && sda_oe_reg) begin
      prior_match_reg <= 1'b1;
    end
  end

  assign scl_out = line_low_reg;
  assign sda_out = line_low_reg;
  assign scl_oe_out = scl_oe_reg;
  assign sda_oe_out = sda_oe_reg;
  assign rx_data_out = rxq.out_data;
  assign buffer_full_flag_out = rxq.out_valid;
  assign port_interrupt_flag_out = irq_reg;
  assign receive_overflow_flag_out = ovf_reg;
  assign update_address_flag_out = upd_addr_reg;
  assign ack_time_status_out = ack_time_reg;
  assign received_ack_status_out = rx_ack_reg;
  assign read_write_status_out = rw_reg;
  assign start_seen_out = start_seen_reg;
  assign stop_seen_out = stop_seen_reg;
endmodule

// >>> pkg/i2cs_defines.svh
// Purpose: shared constants of the slave address and acknowledge engine
// Assumes: included by bare name
// Notes: definitions only
`ifndef I2CS_DEFINES_SVH
`define I2CS_DEFINES_SVH
`define I2CS_DATA_W 8
`define I2CS_FIFO_DEPTH 8
`define I2CS_BIT_CNT_W 4
`define I2CS_BITS_PER_BYTE 4'h8
`define I2CS_TEN_HI_PATTERN 5'h1e
`define I2CS_RW_POS 0
`define I2CS_A98_HI 2
`define I2CS_A98_LO 1
`define I2CS_MODE_TEN_POS 0
`define I2CS_MODE_SSIRQ_POS 1
`define I2CS_ADDR_CMP_MASK 8'hfe
`define I2CS_LINE_IDLE 1'b1
`endif

// >>> pkg/i2cs_pkg.sv
// Purpose: types of the slave address and acknowledge engine
// Assumes: nothing
// Notes: constants live in i2cs_defines.svh
package i2cs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BITS = 3'h1,
    ST_HOLD8 = 3'h2,
    ST_ACK = 3'h3,
    ST_HOLD9 = 3'h4
  } i2cs_state_t;
  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_LO = 2'h1,
    PH_DATA = 2'h2
  } i2cs_phase_t;
endpackage

// >>> pkg/i2cs_fifo_if.sv
// Purpose: stream carrier between the engine and its receive FIFO
// Assumes: one clock domain
// Notes: valid and ready on both sides
`timescale 1ns/1ps
interface i2cs_fifo_if #(parameter int W = 8);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, input in_data, input out_ready,
    output in_ready, output out_valid, output out_data);
  modport engine (output in_valid, output in_data, output out_ready,
    input in_ready, input out_valid, input out_data);
endinterface

// >>> rtl/i2cs_rx_fifo.sv
// Purpose: receive FIFO, shift register style, head always in entry 0
// Assumes: single clock
// Notes: all status outputs are flip-flops
`timescale 1ns/1ps
module i2cs_rx_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  i2cs_fifo_if.fifo f
);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_reg [D];
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic [CW-1:0] wr_idx;
  logic nonempty_reg;
  logic ready_reg;
  logic push;
  logic pop;

  assign push = f.in_valid && ready_reg;
  assign pop = f.out_ready && nonempty_reg;
  assign wr_idx = pop ? count_reg - CW'(1) : count_reg;

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + CW'(1);
    end else if (pop && !push) begin
      count_next = count_reg - CW'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_reg <= '0;
      nonempty_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      nonempty_reg <= count_next != '0;
      ready_reg <= count_next != CW'(D);
    end
  end

  // Entries slide toward the head on a pop
  for (genvar i = 0; i < D; i++) begin : g_ent
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
        mem_reg[i] <= '0;
      end else if (push && wr_idx == CW'(i)) begin
        mem_reg[i] <= f.in_data;
      end else if (pop && i < D - 1) begin
        mem_reg[i] <= mem_reg[(i + 1) % D];
      end
    end
  end

  assign f.in_ready = ready_reg;
  assign f.out_valid = nonempty_reg;
  assign f.out_data = mem_reg[0];
endmodule

// >>> tb/i2cs_master_model.sv
// Purpose: bus master partner driving clock and data lines
// Assumes: open-drain lines with pull-ups, resolved in the bench
// Notes: clock stands still between frames
`timescale 1ns/1ps
module i2cs_master_model (
  input wire logic scl_w_in,
  input wire logic sda_w_in,
  output logic scl_m_out,
  output logic sda_m_out
);
  initial begin
    scl_m_out = 1'b1;
    sda_m_out = 1'b1;
  end
  // data moves while low, ack sampled high
  task automatic bit_x(input logic b, output logic r);
    sda_m_out = b;
    #40 scl_m_out = 1'b1;
    wait (scl_w_in);
    #40 r = sda_w_in;
    #40 scl_m_out = 1'b0;
    #40;
  endtask
  task automatic start();
    sda_m_out = 1'b1;
    #40 scl_m_out = 1'b1;
    wait (scl_w_in);
    #40 sda_m_out = 1'b0;
    #80 scl_m_out = 1'b0;
    #40;
  endtask
  task automatic stop();
    sda_m_out = 1'b0;
    #40 scl_m_out = 1'b1;
    wait (scl_w_in);
    #80 sda_m_out = 1'b1;
    #160;
  endtask
  // eight bits then a released ack slot
  task automatic wr(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, a);
  endtask
endmodule

// >>> tb/i2cs_addr_ack_slave_assertions.sv
// Purpose: port-level checks of the slave engine
// Assumes: pins resolved outside, bus clock far slower than clk_sys_in
// Notes: windows allow for the two-flop input synchroniser
`timescale 1ns/1ps
module i2cs_addr_ack_slave_assertions (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic scl_oe_out,
  input wire logic sda_oe_out,
  input wire logic enable_in,
  input wire logic [1:0] port_mode_select_in,
  input wire logic address_hold_enable_in,
  input wire logic data_hold_enable_in,
  input wire logic clock_release_in,
  input wire logic own_address_write_in,
  input wire logic irq_clear_in,
  input wire logic port_interrupt_flag_out,
  input wire logic update_address_flag_out,
  input wire logic ack_time_status_out,
  input wire logic start_seen_out,
  input wire logic stop_seen_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  logic low_seen_reg;
  // Tracks a clock-low interval since the last Start
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_seen_reg <= 1'b0;
    end else if (scl_in && $fell(sda_in)) begin
      low_seen_reg <= 1'b0;
    end else if (!scl_in) begin
      low_seen_reg <= 1'b1;
    end
  end
  sequence s_start;
    enable_in && scl_in && $fell(sda_in);
  endsequence
  sequence s_stop;
    enable_in && scl_in && low_seen_reg && $rose(sda_in);
  endsequence
  chk_pins_open_drain: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
  chk_start_flag: assert property (s_start |-> ##[1:6] start_seen_out)
    else $error("start flag missing");
  chk_stop_flag: assert property (s_stop |-> ##[1:6] stop_seen_out)
    else $error("stop flag missing");
  chk_cond_irq: assert property (s_start ##0 port_mode_select_in[1]
    |-> ##[1:6] port_interrupt_flag_out)
    else $error("condition irq missing");
  chk_ack_stands: assert property ($rose(scl_in) && sda_oe_out
    |=> sda_oe_out [*4])
    else $error("ack dropped while clock high");
  chk_release_drop: assert property (scl_oe_out && clock_release_in
    && !update_address_flag_out |-> ##[1:2] !scl_oe_out)
    else $error("clock hold not released");
  chk_ua_clear: assert property (update_address_flag_out
    && own_address_write_in |-> ##[1:2] !update_address_flag_out)
    else $error("update flag not cleared");
  chk_irq_sticky: assert property (enable_in && port_interrupt_flag_out
    && !irq_clear_in |=> port_interrupt_flag_out)
    else $error("irq flag lost");
  chk_acktime_gate: assert property (ack_time_status_out
    |-> address_hold_enable_in || data_hold_enable_in)
    else $error("ack time without hold");
endmodule
bind i2cs_addr_ack_slave i2cs_addr_ack_slave_assertions chk_i (.*);

// >>> tb/i2cs_addr_ack_slave_tb_top.sv
// Purpose: self-checking bench of the slave engine
// Assumes: master model drives the bus, open-drain wired-and
// Notes: config changes land on falling clock edges
`timescale 1ns/1ps
module i2cs_addr_ack_slave_tb_top;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, enable_in = 1'b1;
  logic [1:0] port_mode_select_in = 2'h0;
  logic [7:0] own_address_primary_in = 8'ha0;
  logic [7:0] own_address_secondary_in = 8'h62;
  logic [7:0] address_mask_primary_in = 8'hfe;
  logic [7:0] address_mask_secondary_in = 8'hfe;
  logic address_hold_enable_in = 1'b0, data_hold_enable_in = 1'b0;
  logic start_irq_enable_in = 1'b0, stop_irq_enable_in = 1'b0;
  logic stretch_enable_in = 1'b0, buffer_overwrite_enable_in = 1'b0;
  logic ack_data_value_in = 1'b0, clock_release_in = 1'b0;
  logic own_address_write_in = 1'b0, irq_clear_in = 1'b0;
  logic overflow_clear_in = 1'b0, rx_read_in = 1'b0;
  logic [7:0] rx_data_out;
  logic scl_out, scl_oe_out, sda_out, sda_oe_out, buffer_full_flag_out;
  logic port_interrupt_flag_out, receive_overflow_flag_out;
  logic update_address_flag_out, ack_time_status_out;
  logic received_ack_status_out, read_write_status_out;
  logic start_seen_out, stop_seen_out, scl_m, sda_m, a;
  wire scl_in, sda_in;
  int n_errors = 0, checks = 0, cyc = 0;
  // Pull-ups: a line is low while either party pulls it
  assign scl_in = scl_m & !scl_oe_out;
  assign sda_in = sda_m & !sda_oe_out;
  i2cs_addr_ack_slave DUT (.*);
  i2cs_master_model m (.scl_w_in(scl_in), .sda_w_in(sda_in),
    .scl_m_out(scl_m), .sda_m_out(sda_m));
  always #10 clk_sys_in = !clk_sys_in;
  task automatic give_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys_in);
    s = 1'b1;
    @(negedge clk_sys_in);
    s = 1'b0;
  endtask
  task automatic wb(input logic [7:0] d, input logic e);
    m.wr(d, a);
    repeat (6) @(negedge clk_sys_in);
    cmp(a, e);
  endtask
  task automatic rd(input logic [7:0] e);
    cmp(rx_data_out, e);
    pulse(rx_read_in);
    @(negedge clk_sys_in);
  endtask
  // Bounded wait for a clock hold, then the given release pulse
  task automatic hold_rel(ref logic s);
    int k;
    k = 0;
    while (!scl_oe_out && k < 300) begin
      @(negedge clk_sys_in);
      k++;
    end
    cmp(scl_oe_out, 1);
    pulse(s);
  endtask
  initial begin
    repeat (10) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    m.start();
    cmp(start_seen_out, 1);
    wb(8'ha0, 1'b0);
    cmp(read_write_status_out, 0);
    cmp(port_interrupt_flag_out, 1);
    rd(8'ha0);
    cmp(buffer_full_flag_out, 0);
    wb(8'h3c, 1'b0);
    cmp(received_ack_status_out, 0);
    m.stop();
    cmp(stop_seen_out, 1);
    rd(8'h3c);
    pulse(irq_clear_in);
    cmp(port_interrupt_flag_out, 0);
    m.start();
    wb(8'h63, 1'b0);
    cmp(read_write_status_out, 1);
    m.stop();
    rd(8'h63);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_sys_in);
      address_mask_primary_in = i ? 8'hfe : 8'hf0;
      m.start();
      wb(8'ha6, i[0]);
      cmp(buffer_full_flag_out, !i[0]);
      cmp(received_ack_status_out, 1'b0);
      m.stop();
      if (i == 0) begin
        rd(8'ha6);
      end
    end
    m.start();
    wb(8'ha0, 1'b0);
    wb(8'h11, 1'b1);
    cmp(receive_overflow_flag_out, 1);
    m.stop();
    pulse(overflow_clear_in);
    cmp(receive_overflow_flag_out, 0);
    rd(8'ha0);
    buffer_overwrite_enable_in = 1'b1;
    m.start();
    wb(8'ha0, 1'b0);
    for (int i = 0; i < 7; i++) begin
      wb(i[7:0], 1'b0);
    end
    wb(8'hee, 1'b1);
    m.stop();
    pulse(overflow_clear_in);
    rd(8'ha0);
    for (int i = 0; i < 7; i++) begin
      rd(i[7:0]);
    end
    cmp(buffer_full_flag_out, 0);
    address_hold_enable_in = 1'b1;
    for (int v = 1; v >= 0; v--) begin
      @(negedge clk_sys_in);
      ack_data_value_in = v[0];
      m.start();
      fork
        m.wr(8'ha0, a);
        begin
          hold_rel(clock_release_in);
          cmp(ack_time_status_out, 1);
        end
      join
      cmp(a, v[0]);
      cmp(received_ack_status_out, v[0]);
      m.stop();
      cmp(ack_time_status_out, 0);
      rd(8'ha0);
    end
    @(negedge clk_sys_in);
    address_hold_enable_in = 1'b0;
    stretch_enable_in = 1'b1;
    m.start();
    wb(8'ha0, 1'b0);
    cmp(scl_oe_out, 1);
    hold_rel(clock_release_in);
    rd(8'ha0);
    wb(8'h55, 1'b0);
    hold_rel(clock_release_in);
    m.stop();
    rd(8'h55);
    stretch_enable_in = 1'b0;
    port_mode_select_in = 2'h2;
    pulse(irq_clear_in);
    m.start();
    cmp(port_interrupt_flag_out, 1);
    pulse(irq_clear_in);
    wb(8'h44, 1'b1);
    m.stop();
    cmp(port_interrupt_flag_out, 1);
    port_mode_select_in = 2'h1;
    own_address_primary_in = 8'h04;
    m.start();
    wb(8'hf4, 1'b0);
    cmp(update_address_flag_out, 1);
    own_address_primary_in = 8'h5a;
    hold_rel(own_address_write_in);
    cmp(update_address_flag_out, 0);
    wb(8'h5a, 1'b0);
    cmp(update_address_flag_out, 1);
    own_address_primary_in = 8'h04;
    hold_rel(own_address_write_in);
    m.start();
    wb(8'hf5, 1'b0);
    cmp(read_write_status_out, 1);
    m.stop();
    m.start();
    wb(8'hf5, 1'b1);
    m.stop();
    port_mode_select_in = 2'h0;
    start_irq_enable_in = 1'b1;
    stop_irq_enable_in = 1'b1;
    pulse(irq_clear_in);
    m.start();
    cmp(port_interrupt_flag_out, 1);
    pulse(irq_clear_in);
    m.stop();
    cmp(port_interrupt_flag_out, 1);
    give_verdict();
  end
endmodule
